// *** hdl/rcr_pkg.sv ***
package rcr_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CONV5_CONTROL_OFS = 8'h26;
   localparam logic [7:0] CONV6_CONTROL_OFS = 8'h27;
   localparam logic [7:0] REG_A2_CONTROL_OFS = 8'h28;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int RAIL_ON_BIT = 0;
   localparam int MODE_BIT = 1;
   localparam int SLEEP_LO = 4;
   localparam int SLEEP_HI = 5;
   localparam int RES_HI = 7;
   localparam int RES_LO = 6;

   // Control pins that may serve as sleep inputs
   localparam int SLEEP_PIN1_IDX = 2;
   localparam int SLEEP_PIN2_IDX = 5;

   // Sleep select codes
   localparam logic [1:0] SLEEP_OFF = 2'h0;
   localparam logic [1:0] SLEEP_ON = 2'h3;

   // Read-only top bits always read zero
   localparam logic [7:0] RO_MASK = 8'hc0;

   // Factory default of one variant; real parts strap their own
   localparam logic [7:0] CONV5_RESET = 8'h0f;
   localparam logic [7:0] CONV6_RESET = 8'h0d;
   localparam logic [7:0] REG_A2_RESET = 8'h0c;

   // Number of rails in this bank
   localparam int NUM_RAILS = 3;

endpackage

// *** hdl/rcr_rail_control_registers.sv ***
`timescale 1ns/100ps
`default_nettype none

module rcr_rail_control_registers #(
   parameter logic [7:0] CONV5_DEFAULT = rcr_pkg::CONV5_RESET,
   parameter logic [7:0] CONV6_DEFAULT = rcr_pkg::CONV6_RESET,
   parameter logic [7:0] REG_A2_DEFAULT = rcr_pkg::REG_A2_RESET,
   // Bit n high: rail n sleeps on control pin 6, else control pin 3
   parameter logic [2:0] SLEEP_PIN_SEL = 3'h0
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_hit_o,
   input wire logic [5:0] control_input_pins_i,
   input wire logic [2:0] rail_pin_enable_i,
   output logic [2:0] rail_enable_o,
   output logic [2:0] rail_use_sleep_o,
   output logic conv5_forced_pwm_o,
   output logic conv6_forced_pwm_o
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Sync flops carry no reset; hold reset two cycles to flush them
   // Only the second flop of each pair feeds the rail logic
   logic [5:0] pin_meta_q;
   logic [5:0] pin_meta_d;
   logic [5:0] pin_sync_q;
   logic [5:0] pin_sync_d;
   logic [2:0] en_meta_q;
   logic [2:0] en_meta_d;
   logic [2:0] en_sync_q;
   logic [2:0] en_sync_d;

   always_comb begin
      pin_meta_d = pin_meta_q;
      pin_sync_d = pin_sync_q;
      en_meta_d = en_meta_q;
      en_sync_d = en_sync_q;
      if (clk_en_i) begin
         pin_meta_d = control_input_pins_i;
         pin_sync_d = pin_meta_q;
         en_meta_d = rail_pin_enable_i;
         en_sync_d = en_meta_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
      en_meta_q <= en_meta_d;
      en_sync_q <= en_sync_d;
   end

   // ****************************************
   // Register bank
   // ****************************************
   logic [7:0] ctl_q [rcr_pkg::NUM_RAILS];
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [rcr_pkg::NUM_RAILS-1:0] sel;

   // Per-register defaults, indexed like sel
   localparam logic [7:0] RESET_VALUE [rcr_pkg::NUM_RAILS] =
      '{CONV5_DEFAULT, CONV6_DEFAULT, REG_A2_DEFAULT};

   // Consecutive byte offsets, one register per rail
   always_comb begin
      sel = '0;
      if (reg_addr_i == rcr_pkg::CONV5_CONTROL_OFS) begin
         sel[0] = 1'b1;
      end else if (reg_addr_i == rcr_pkg::CONV6_CONTROL_OFS) begin
         sel[1] = 1'b1;
      end else if (reg_addr_i == rcr_pkg::REG_A2_CONTROL_OFS) begin
         sel[2] = 1'b1;
      end
   end

   assign reg_hit_o = |sel;

   // Reserved patterns are stored as written; host keeps them right
   for (genvar r = 0; r < rcr_pkg::NUM_RAILS; r++) begin : g_reg
      logic [7:0] reg_q;
      logic [7:0] reg_d;

      always_comb begin
         reg_d = reg_q;
         if (clk_en_i && reg_wr_i && sel[r]) begin
            // Bits 7:6 are read only and stay zero
            reg_d = reg_wdata_i & ~rcr_pkg::RO_MASK;
         end
      end

      always_ff @(posedge core_clk_i) begin
         if (!nrst_i) begin
            reg_q <= RESET_VALUE[r];
         end else begin
            reg_q <= reg_d;
         end
      end

      assign ctl_q[r] = reg_q;
   end

   // Unmapped reads return zero; a read beside a write sees the old value
   always_comb begin
      rdata_d = rdata_q;
      if (clk_en_i && reg_rd_i) begin
         rdata_d = 8'h00;
         for (int i = 0; i < rcr_pkg::NUM_RAILS; i++) begin
            if (sel[i]) begin
               rdata_d = ctl_q[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ****************************************
   // Rail controls
   // ****************************************
   logic [1:0] pwm_q;
   logic [1:0] pwm_d;

   // Outputs are registered so rails never see decode glitches
   for (genvar g = 0; g < rcr_pkg::NUM_RAILS; g++) begin : g_rail
      logic en_q;
      logic en_d;
      logic slp_q;
      logic slp_d;
      logic [1:0] sleep_code;
      logic sleep_pin;

      assign sleep_code = ctl_q[g][rcr_pkg::SLEEP_HI:rcr_pkg::SLEEP_LO];

      // Pin choice is a strap, so software cannot move it
      assign sleep_pin = SLEEP_PIN_SEL[g] ?
                         pin_sync_q[rcr_pkg::SLEEP_PIN2_IDX] :
                         pin_sync_q[rcr_pkg::SLEEP_PIN1_IDX];

      always_comb begin
         en_d = en_q;
         slp_d = slp_q;
         if (clk_en_i) begin
            // Register bit low overrides any pin request
            en_d = en_sync_q[g] & ctl_q[g][rcr_pkg::RAIL_ON_BIT];
            // Reserved codes 01 and 10 keep the normal voltage
            slp_d = (sleep_code == rcr_pkg::SLEEP_ON) && !sleep_pin;
         end
      end

      always_ff @(posedge core_clk_i) begin
         if (!nrst_i) begin
            en_q <= 1'b0;
            slp_q <= 1'b0;
         end else begin
            en_q <= en_d;
            slp_q <= slp_d;
         end
      end

      assign rail_enable_o[g] = en_q;
      assign rail_use_sleep_o[g] = slp_q;
   end

   // Mode bit exists on the two converters only
   always_comb begin
      pwm_d = pwm_q;
      if (clk_en_i) begin
         pwm_d[0] = ctl_q[0][rcr_pkg::MODE_BIT];
         pwm_d[1] = ctl_q[1][rcr_pkg::MODE_BIT];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pwm_q <= 2'h0;
      end else begin
         pwm_q <= pwm_d;
      end
   end

   assign conv5_forced_pwm_o = pwm_q[0];
   assign conv6_forced_pwm_o = pwm_q[1];

endmodule

`default_nettype wire

// *** verif/rail_control_registers_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module rail_control_registers_tb;
   logic clk = 1'h0, nrst = 1'h0, wr, rd, hit, p5, p6;
   logic [5:0] pins = 6'h3f;
   logic [7:0] a, d, q;
   logic [2:0] en, slp;
   logic [2:0] pen = 3'h7;
   logic ce = 1'h1;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   logic [23:0] rows [5] = '{24'h260e0e, 24'h273f3f, 24'h280d0d,
      24'h29ff00, 24'h26ff3f};
   always #5 clk = ~clk;
   rcr_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .a_o(a), .d_o(d));
   rcr_rail_control_registers uut (.core_clk_i(clk), .nrst_i(nrst),
      .clk_en_i(ce), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(a),
      .reg_wdata_i(d), .reg_rdata_o(q), .reg_hit_o(hit),
      .control_input_pins_i(pins), .rail_pin_enable_i(pen),
      .rail_enable_o(en), .rail_use_sleep_o(slp),
      .conv5_forced_pwm_o(p5), .conv6_forced_pwm_o(p6));
   task chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Generous ceiling: the whole run needs some sixty cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'h1;
      host.rd(8'h26);
      chk(q, rcr_pkg::CONV5_RESET);
      host.rd(8'h27);
      chk(q, rcr_pkg::CONV6_RESET);
      host.rd(8'h28);
      chk(q, rcr_pkg::REG_A2_RESET);
      foreach (rows[i]) begin
         host.wr(rows[i][23:16], rows[i][15:8]);
         host.rd(rows[i][23:16]);
         chk(q, rows[i][7:0]);
      end
      $display("register test done");
      chk({7'h0, p5}, 8'h1);
      chk({5'h0, en}, 8'h7);
      pins[2] = 1'h0;
      repeat (4) @(negedge clk);
      chk({5'h0, slp}, 8'h3);
      {pins[5], pins[2]} = 2'h1;
      repeat (4) @(negedge clk);
      chk({5'h0, slp}, 8'h0);
      // Pin request low on one rail turns only that rail off
      pen = 3'h5;
      repeat (4) @(negedge clk);
      chk({5'h0, en}, 8'h5);
      pen = 3'h7;
      repeat (4) @(negedge clk);
      host.wr(8'h26, 8'h0c);
      @(negedge clk);
      chk({4'h0, en, p5}, 8'hc);
      $display("rail test done");
      // Clock enable low: the write must not land
      ce = 1'h0;
      host.wr(8'h26, 8'h0f);
      ce = 1'h1;
      host.rd(8'h26);
      chk(q, 8'h0c);
      $display("clock enable test done");
      // Reset in mid-run brings back the defaults
      nrst = 1'h0;
      repeat (2) @(negedge clk);
      nrst = 1'h1;
      host.rd(8'h26);
      chk(q, rcr_pkg::CONV5_RESET);
      chk({5'h0, en}, {5'h0, rcr_pkg::REG_A2_RESET[0],
         rcr_pkg::CONV6_RESET[0], rcr_pkg::CONV5_RESET[0]});
      $display("reset test done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** verif/rcr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rcr_host_model (
   input wire logic clk_i,
   output logic wr_o = 1'h0,
   output logic rd_o = 1'h0,
   output logic [7:0] a_o = 8'h0,
   output logic [7:0] d_o = 8'h0
);
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h26 || a == 8'h27) v[3:2] = 2'h3;
      if (a == 8'h28) v[3:1] = 3'h6;
      if (v[5] != v[4]) v[5:4] = 2'h0;
      @(negedge clk_i);
      {wr_o, a_o, d_o} = {1'h1, a, v};
      @(negedge clk_i);
      {wr_o, a_o, d_o} = {1'h0, ~a, ~v};
   endtask
   task rd(input logic [7:0] a);
      @(negedge clk_i);
      {rd_o, a_o} = {1'h1, a};
      @(negedge clk_i);
      {rd_o, a_o} = {1'h0, ~a};
   endtask
endmodule
`default_nettype wire

// *** verif/rcr_rail_control_registers_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module rcr_chk (
   input wire logic core_clk_i, nrst_i, clk_en_i, reg_wr_i, reg_rd_i,
   input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire logic reg_hit_o, conv5_forced_pwm_o, conv6_forced_pwm_o,
   input wire logic [5:0] control_input_pins_i,
   input wire logic [2:0] rail_pin_enable_i, rail_enable_o, rail_use_sleep_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   wire w5 = reg_wr_i && clk_en_i && reg_addr_i == 8'h26;
   wire wa = reg_wr_i && clk_en_i && reg_addr_i == 8'h28;
   property p_hit;
      reg_hit_o == (reg_addr_i inside {8'h26, 8'h27, 8'h28});
   endproperty
   a_hit: assert property (p_hit) else $error("hit");
   property p_unmap;
      reg_rd_i && clk_en_i && reg_addr_i > 8'h28 |=> reg_rdata_o == 8'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmap");
   property p_mode;
      w5 |-> ##2 conv5_forced_pwm_o == $past(reg_wdata_i[1], 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_off;
      w5 && !reg_wdata_i[0] |-> ##2 !rail_enable_o[0];
   endproperty
   a_off: assert property (p_off) else $error("off");
   property p_slp;
      wa && reg_wdata_i[5:4] == 2'h0 |-> ##2 !rail_use_sleep_o[2];
   endproperty
   a_slp: assert property (p_slp) else $error("slp");
   // Two samples of the pin hedge the synchroniser depth
   property p_pin;
      $past(control_input_pins_i[2], 3) && $past(control_input_pins_i[2], 4)
         |-> !rail_use_sleep_o[1];
   endproperty
   a_pin: assert property (p_pin) else $error("pin");
   property p_rst;
      $rose(nrst_i) |-> rail_enable_o == 3'h0 && reg_rdata_o == 8'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("rst");
   c_w5: cover property (w5);
   c_slp: cover property (rail_use_sleep_o[1]);
   c_un: cover property (reg_rd_i && !reg_hit_o);
endmodule
bind rcr_rail_control_registers rcr_chk u_chk (.*);
`default_nettype wire
